// ==== include/lamp_pwr_pkg.sv ====
`default_nettype none
package lamp_pwr_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned LAMP_ON_DELAY_MS = 100;
  localparam int unsigned MIRROR_HOLD_US = 500;
  // least time rounds up
  localparam int unsigned LAMP_ON_CYCLES_DEF = (LAMP_ON_DELAY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // longest-hold reading: exact multiple here, rounding down
  localparam int unsigned MIRROR_HOLD_CYCLES = (MIRROR_HOLD_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 24;
  // ==========================================================
  // lamp select codes
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_RED = 2'h1;
  localparam logic [1:0] SEL_GREEN = 2'h2;
  localparam logic [1:0] SEL_BLUE = 2'h3;
  // ==========================================================
  // reset values
  localparam logic [CNT_W-1:0] CNT_RESET = 24'h00_0000;
  localparam logic [2:0] PWM_RESET = 3'h7;
endpackage
`default_nettype wire

// ==== hw/lamp_power_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
module lamp_power_ctrl
  import lamp_pwr_pkg::*;
#(
  parameter int unsigned LAMP_ON_CYCLES = LAMP_ON_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic lamp_request,
  input wire logic park,
  input wire logic companion_fitted,
  input wire logic sw_lamp_ctrl_en,
  input wire logic seq_running,
  input wire logic [1:0] seq_lamp_select,
  input wire logic [2:0] seq_pwm,
  input wire logic [2:0] cpu_gpio,
  output logic red_pwm_out,
  output logic green_pwm_out,
  output logic blue_pwm_out,
  output logic lamp_select_lsb,
  output logic lamp_select_msb,
  output logic lamp_driver_master_en,
  output logic mirror_supply_en
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [1:0] req_sync;
    logic [1:0] park_sync;
    logic [CNT_W-1:0] on_cnt;
    logic [CNT_W-1:0] hold_cnt;
    logic master_en;
    logic mirror_en;
    logic [1:0] sel;
    logic [2:0] pwm;
    // watch counters, read only by the assertions
    logic [CNT_W-1:0] req_run_cnt;
    logic [CNT_W-1:0] park_low_cnt;
  } state_t;

  localparam state_t STATE_RESET = '{
    req_sync: 2'h0,
    park_sync: 2'h0,
    on_cnt: CNT_RESET,
    hold_cnt: CNT_RESET,
    master_en: 1'h0,
    mirror_en: 1'h0,
    sel: SEL_NONE,
    pwm: PWM_RESET,
    req_run_cnt: CNT_RESET,
    park_low_cnt: CNT_RESET
  };

  state_t s_q;
  state_t s_d;
  logic req_s;
  logic park_s;

  assign req_s = s_q.req_sync[1];
  assign park_s = s_q.park_sync[1];

  always_comb begin
    s_d = s_q;
    // ==========================================================
    // two-flop synchronisers; only the second stage, bit 1, is read by logic
    s_d.req_sync = {s_q.req_sync[0], lamp_request};
    s_d.park_sync = {s_q.park_sync[0], park};
    // ==========================================================
    // lamp driver enable: delay counts only while both are high
    if (!req_s || !park_s) begin
      s_d.on_cnt = CNT_RESET;
      s_d.master_en = 1'b0;
    end else if (s_q.on_cnt >= CNT_W'(LAMP_ON_CYCLES - 1)) begin
      s_d.master_en = 1'b1;
    end else begin
      s_d.on_cnt = CNT_W'(s_q.on_cnt + 1'b1);
    end
    // ==========================================================
    // mirror supply enable with hold after park falls
    if (park_s) begin
      s_d.mirror_en = 1'b1;
      s_d.hold_cnt = CNT_RESET;
    end else if (s_q.mirror_en) begin
      if (s_q.hold_cnt >= CNT_W'(MIRROR_HOLD_CYCLES - 1)) begin
        s_d.mirror_en = 1'b0;
      end else begin
        s_d.hold_cnt = CNT_W'(s_q.hold_cnt + 1'b1);
      end
    end
    // ==========================================================
    // lamp select, one cycle behind the sequencer
    s_d.sel = seq_lamp_select;
    // ==========================================================
    // lamp pwm or plain outputs
    if (companion_fitted) begin
      s_d.pwm = cpu_gpio;
    end else if (!s_q.master_en || !sw_lamp_ctrl_en || !seq_running) begin
      s_d.pwm = PWM_RESET;
    end else begin
      s_d.pwm = seq_pwm;
    end
    // ==========================================================
    // watch counters: saturate so a long run never wraps
    if (req_s && park_s) begin
      if (s_q.req_run_cnt != '1) begin
        s_d.req_run_cnt = CNT_W'(s_q.req_run_cnt + 1'b1);
      end
    end else begin
      s_d.req_run_cnt = CNT_RESET;
    end
    if (!park_s) begin
      if (s_q.park_low_cnt != '1) begin
        s_d.park_low_cnt = CNT_W'(s_q.park_low_cnt + 1'b1);
      end
    end else begin
      s_d.park_low_cnt = CNT_RESET;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= STATE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign red_pwm_out = s_q.pwm[0];
  assign green_pwm_out = s_q.pwm[1];
  assign blue_pwm_out = s_q.pwm[2];
  assign lamp_select_lsb = s_q.sel[0];
  assign lamp_select_msb = s_q.sel[1];
  assign lamp_driver_master_en = s_q.master_en;
  assign mirror_supply_en = s_q.mirror_en;

  // ==========================================================
  // checks
  a_master_drop_fast: assert property (@(posedge clk) disable iff (rst)
    (!req_s || !park_s) |=> !lamp_driver_master_en)
    else $error("master enable not dropped");

  a_master_not_early: assert property (@(posedge clk) disable iff (rst)
    $rose(lamp_driver_master_en) |-> $past(req_s, 2) && $past(park_s, 2))
    else $error("master enable early");

  a_master_min_wait: assert property (@(posedge clk) disable iff (rst)
    lamp_driver_master_en |-> (s_q.req_run_cnt >= CNT_W'(LAMP_ON_CYCLES)))
    else $error("master enable before the delay ran out");

  a_master_on_time: assert property (@(posedge clk) disable iff (rst)
    (s_q.req_run_cnt >= CNT_W'(LAMP_ON_CYCLES)) |-> lamp_driver_master_en)
    else $error("master enable late");

  a_on_count_cap: assert property (@(posedge clk) disable iff (rst)
    s_q.on_cnt < CNT_W'(LAMP_ON_CYCLES))
    else $error("lamp delay counter overran");

  a_master_with_mirror: assert property (@(posedge clk) disable iff (rst)
    lamp_driver_master_en |-> mirror_supply_en)
    else $error("master enable high with mirror supply off");

  a_mirror_on_park: assert property (@(posedge clk) disable iff (rst)
    park_s |=> mirror_supply_en)
    else $error("mirror enable low while parked high");

  a_mirror_rise_park: assert property (@(posedge clk) disable iff (rst)
    $rose(mirror_supply_en) |-> $past(park_s))
    else $error("mirror enable rose without park");

  a_mirror_hold_end: assert property (@(posedge clk) disable iff (rst)
    $fell(mirror_supply_en) |-> !park_s && s_q.hold_cnt == CNT_W'(MIRROR_HOLD_CYCLES - 1))
    else $error("mirror enable fell at wrong time");

  a_mirror_hold_full: assert property (@(posedge clk) disable iff (rst)
    $fell(mirror_supply_en) |-> (s_q.park_low_cnt == CNT_W'(MIRROR_HOLD_CYCLES)))
    else $error("mirror hold not the full time");

  a_mirror_off_late: assert property (@(posedge clk) disable iff (rst)
    (s_q.park_low_cnt >= CNT_W'(MIRROR_HOLD_CYCLES)) |-> !mirror_supply_en)
    else $error("mirror enable held too long");

  a_hold_count_cap: assert property (@(posedge clk) disable iff (rst)
    s_q.hold_cnt < CNT_W'(MIRROR_HOLD_CYCLES))
    else $error("mirror hold counter overran");

  a_pwm_forced_high: assert property (@(posedge clk) disable iff (rst)
    (!companion_fitted && !seq_running) |=> (s_q.pwm == PWM_RESET))
    else $error("pwm not forced high");

  a_pwm_master_off: assert property (@(posedge clk) disable iff (rst)
    (!companion_fitted && !lamp_driver_master_en) |=> (s_q.pwm == PWM_RESET))
    else $error("pwm not high with master enable off");

  a_pwm_sw_off: assert property (@(posedge clk) disable iff (rst)
    (!companion_fitted && !sw_lamp_ctrl_en) |=> (s_q.pwm == PWM_RESET))
    else $error("pwm not high with software control off");

  a_pwm_gpio_mode: assert property (@(posedge clk) disable iff (rst)
    companion_fitted |=> s_q.pwm == $past(cpu_gpio))
    else $error("gpio mode mismatch");

  a_select_follow: assert property (@(posedge clk) disable iff (rst)
    1'b1 |=> {lamp_select_msb, lamp_select_lsb} == $past(seq_lamp_select))
    else $error("select lag wrong");

  a_pwm_pass: assert property (@(posedge clk) disable iff (rst)
    (!companion_fitted && lamp_driver_master_en && sw_lamp_ctrl_en && seq_running)
    |=> {blue_pwm_out, green_pwm_out, red_pwm_out} == $past(seq_pwm))
    else $error("pwm pass wrong");

  a_reset_values: assert property (@(posedge clk) rst |=>
    (s_q.pwm == PWM_RESET && !lamp_driver_master_en && !mirror_supply_en && s_q.sel == SEL_NONE))
    else $error("outputs not at reset values");
endmodule
`default_nettype wire

// ==== verif/lamp_decode.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========
// outside decoder: one enable per colour
module lamp_decode (
  input wire logic [1:0] sel,
  output logic [2:0] lamp_on
);
  assign lamp_on = {sel == 2'h3, sel == 2'h2, sel == 2'h1};
endmodule
`default_nettype wire

// ==== verif/tb_lamp_power_ctrl.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========
module tb_lamp_power_ctrl;
  import lamp_pwr_pkg::*;
  logic clk, rst, req, park, comp, sw, run, r, g, b, lsb, msb, men, mir;
  logic [1:0] sel;
  logic [2:0] spwm, gpio, lon;
  int err_total, n_compared, cyc_n;
  localparam int LAMP_ON_SIM = 20;
  localparam int CYCLE_LIMIT = 60000;
  lamp_power_ctrl #(.LAMP_ON_CYCLES(LAMP_ON_SIM)) u_lamp_power_ctrl (.clk(clk), .rst(rst), .lamp_request(req),
    .park(park), .companion_fitted(comp), .sw_lamp_ctrl_en(sw), .seq_running(run), .seq_lamp_select(sel),
    .seq_pwm(spwm), .cpu_gpio(gpio), .red_pwm_out(r), .green_pwm_out(g), .blue_pwm_out(b),
    .lamp_select_lsb(lsb), .lamp_select_msb(msb), .lamp_driver_master_en(men), .mirror_supply_en(mir));
  lamp_decode u_lamp_decode (.sel({msb, lsb}), .lamp_on(lon));
  task automatic chk(input logic [3:0] v, input logic [3:0] e);
    n_compared++;
    if (v !== e) begin
      err_total++;
      $display("wrong value at %0t: got %h want %h", $time, v, e);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic print_verdict;
    $display("compared %0d, errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic t_lamp;
    park = 1;
    req = 1;
    wt(LAMP_ON_SIM - 1);
    chk({3'h0, men}, 4'h0);
    chk({3'h0, mir}, 4'h1);
    wt(5);
    chk({3'h0, men}, 4'h1);
    req = 0;
    wt(4);
    chk({3'h0, men}, 4'h0);
    req = 1;
    wt(LAMP_ON_SIM + 4);
    chk({3'h0, men}, 4'h1);
  endtask
  task automatic t_pwm;
    spwm = 3'h5;
    wt(2);
    chk({1'h0, b, g, r}, 4'h5);
    sw = 0;
    wt(2);
    chk({1'h0, b, g, r}, 4'h7);
    sw = 1;
    run = 0;
    wt(2);
    chk({1'h0, b, g, r}, 4'h7);
    run = 1;
    comp = 1;
    gpio = 3'h2;
    wt(2);
    chk({1'h0, b, g, r}, 4'h2);
  endtask
  task automatic t_sel;
    for (int i = 0; i < 4; i++) begin
      sel = 2'(i);
      wt(2);
      chk({2'h0, msb, lsb}, 4'(i));
      chk({1'h0, lon}, (i == 0) ? 4'h0 : 4'(1 << (i - 1)));
    end
  endtask
  task automatic t_mirror;
    comp = 0;
    wt(2);
    chk({1'h0, b, g, r}, 4'h5);
    park = 0;
    wt(5);
    chk({3'h0, men}, 4'h0);
    chk({1'h0, b, g, r}, 4'h7);
    chk({3'h0, mir}, 4'h1);
    wt(MIRROR_HOLD_CYCLES - 6);
    chk({3'h0, mir}, 4'h1);
    wt(5);
    chk({3'h0, mir}, 4'h0);
  endtask
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n > CYCLE_LIMIT) begin
      err_total++;
      print_verdict();
    end
  end
  initial begin
    rst = 1'h1;
    req = 1'h0;
    park = 1'h0;
    comp = 1'h0;
    sw = 1'h1;
    run = 1'h1;
    sel = 2'h0;
    spwm = 3'h0;
    gpio = 3'h0;
    wt(4);
    chk({b, g, r, men}, 4'he);
    chk({msb, lsb, mir, 1'h0}, 4'h0);
    rst = 0;
    t_lamp();
    t_pwm();
    t_sel();
    t_mirror();
    print_verdict();
  end
endmodule
`default_nettype wire
